// ---- wsg_consts.vh ----
// Constants for the external bus wait-state generator
`ifndef WSG_CONSTS_VH
`define WSG_CONSTS_VH

// ==========================================================
// Register addresses (memory-mapped register space)
`define WSG_ADDR_RANGE_CFG   16'h0028
`define WSG_ADDR_MULT_CTRL   16'h002B

// ==========================================================
// Range config field positions
`define WSG_SEL_BIT          15
`define WSG_IO_HI            14
`define WSG_IO_LO            12
`define WSG_DHI_HI           11
`define WSG_DHI_LO           9
`define WSG_DLO_HI           8
`define WSG_DLO_LO           6
`define WSG_PHI_HI           5
`define WSG_PHI_LO           3
`define WSG_PLO_HI           2
`define WSG_PLO_LO           0

// ==========================================================
// Reset values: every field seven, range select clear
`define WSG_RANGE_CFG_RST    16'h7FFF
`define WSG_DOUBLER_RST      1'h0
`define WSG_ZERO_FIELDS      15'h0000

// ==========================================================
// Address bits that split halves of data space and program pages
`define WSG_DATA_HALF_BIT    15
`define WSG_PROG_HALF_BIT    15

// ==========================================================
// Access space codes
`define WSG_SPACE_PROG       2'h0
`define WSG_SPACE_DATA       2'h1
`define WSG_SPACE_IO         2'h2

// ==========================================================
// Control register, idle read value and synchroniser reset
`define WSG_DOUBLER_BIT      0
`define WSG_CTRL_RSVD        15'h0000
`define WSG_RDATA_IDLE       16'h0000
`define WSG_READY_SYNC_RST   3'h7
`define WSG_READY_OK_RST     1'h1

// ==========================================================
// Wait counter end point and step
`define WSG_CNT_ZERO         4'h0
`define WSG_CNT_ONE          4'h1

`endif

// ---- wsg_wait_state_gen.v ----
// External bus wait-state generator with its two configuration registers
`timescale 1ns/10ps
`default_nettype none
`include "wsg_consts.vh"

module wsg_wait_state_gen #(
	// Range config layout
	parameter FIELD_W  = 3,
	parameter N_FIELDS = 5
) (
	// Clock and reset
	input  wire        clock,
	input  wire        rst_n,
	// Memory-mapped register port
	input  wire [15:0] mmr_addr,
	input  wire        mmr_wr,
	input  wire        mmr_rd,
	input  wire [15:0] mmr_wdata,
	output reg  [15:0] mmr_rdata,
	// External access sequencer
	input  wire        acc_start,
	input  wire [1:0]  acc_space,
	input  wire [19:0] acc_addr,
	output reg         acc_wait,
	output reg         acc_done,
	// External bus ready pin
	input  wire        ready_pin,
	// Power status
	output reg         clk_gated
);

	// ==========================================================
	// State encoding
	localparam [2:0] ST_IDLE  = 3'h1;
	localparam [2:0] ST_COUNT = 3'h2;
	localparam [2:0] ST_READY = 3'h4;

	// Counter is one bit wider than a field so a doubled count fits
	localparam [FIELD_W:0] CNT_ZERO = `WSG_CNT_ZERO;
	localparam [FIELD_W:0] CNT_ONE  = `WSG_CNT_ONE;

	reg  [15:0]         range_cfg_reg;
	reg                 wait_count_doubler_reg;
	reg  [2:0]          state_reg;
	reg  [FIELD_W:0]    count_reg;
	reg  [2:0]          ready_sync_reg;
	reg                 ready_ok_reg;
	reg  [FIELD_W-1:0]  base_sel;
	reg  [FIELD_W:0]    total_sel;
	wire                program_range_select;
	wire                all_zero;
	wire                count_en;
	wire                hit_range_cfg;
	wire                hit_mult_ctrl;
	wire [FIELD_W-1:0]  io_field;
	wire [FIELD_W-1:0]  data_hi_field;
	wire [FIELD_W-1:0]  data_lo_field;
	wire [FIELD_W-1:0]  prog_hi_field;
	wire [FIELD_W-1:0]  prog_lo_field;
	wire                data_upper_hit;
	wire                prog_upper_hit;
	wire [N_FIELDS-1:0] field_busy;

	// Address decode shared by the write and read paths
	assign hit_range_cfg = (mmr_addr == `WSG_ADDR_RANGE_CFG);
	assign hit_mult_ctrl = (mmr_addr == `WSG_ADDR_MULT_CTRL);

	// ==========================================================
	// Field extraction and access range decode
	assign program_range_select = range_cfg_reg[`WSG_SEL_BIT];
	assign io_field             = range_cfg_reg[`WSG_IO_HI:`WSG_IO_LO];
	assign data_hi_field        = range_cfg_reg[`WSG_DHI_HI:`WSG_DHI_LO];
	assign data_lo_field        = range_cfg_reg[`WSG_DLO_HI:`WSG_DLO_LO];
	assign prog_hi_field        = range_cfg_reg[`WSG_PHI_HI:`WSG_PHI_LO];
	assign prog_lo_field        = range_cfg_reg[`WSG_PLO_HI:`WSG_PLO_LO];
	assign data_upper_hit       = acc_addr[`WSG_DATA_HALF_BIT];
	// With range select set the upper program field drops out of the range decode
	assign prog_upper_hit       = !program_range_select && acc_addr[`WSG_PROG_HALF_BIT];

	// ==========================================================
	// Gating detect: the counter only advances while some range asks for waits
	genvar gi;
	generate
		for (gi = 0; gi < N_FIELDS; gi = gi + 1) begin : g_field
			assign field_busy[gi] = |range_cfg_reg[gi*FIELD_W +: FIELD_W];
		end
	endgenerate
	assign all_zero = ~|field_busy;
	assign count_en = ~all_zero;

	// ==========================================================
	// Register writes
	always @(posedge clock) begin
		if (!rst_n) begin
			range_cfg_reg          <= `WSG_RANGE_CFG_RST;
			wait_count_doubler_reg <= `WSG_DOUBLER_RST;
		end else if (mmr_wr) begin
			if (hit_range_cfg)
				range_cfg_reg <= mmr_wdata;
			// Only the doubler bit is stored; reserved bits have nowhere to land
			if (hit_mult_ctrl)
				wait_count_doubler_reg <= mmr_wdata[`WSG_DOUBLER_BIT];
		end
	end

	// ==========================================================
	// Register reads; unmapped addresses return zero
	always @(posedge clock) begin
		if (!rst_n)
			mmr_rdata <= `WSG_RDATA_IDLE;
		else if (mmr_rd && hit_range_cfg)
			mmr_rdata <= range_cfg_reg;
		else if (mmr_rd && hit_mult_ctrl)
			mmr_rdata <= {`WSG_CTRL_RSVD, wait_count_doubler_reg};
		// Idle bus reads zero so a missed strobe shows up as a clean mismatch
		else
			mmr_rdata <= `WSG_RDATA_IDLE;
	end

	// ==========================================================
	// Range select for the access being started
	always @* begin
		base_sel = prog_lo_field;
		case (acc_space)
			`WSG_SPACE_IO:
				base_sel = io_field;
			`WSG_SPACE_DATA:
				if (data_upper_hit)
					base_sel = data_hi_field;
				else
					base_sel = data_lo_field;
			// Unused space code 3 is served as program space
			default:
				if (prog_upper_hit)
					base_sel = prog_hi_field;
				else
					base_sel = prog_lo_field;
		endcase
		// Doubling is a shift, so at most 14 waits
		total_sel = wait_count_doubler_reg ? {base_sel, 1'h0} : {1'h0, base_sel};
	end

	// ==========================================================
	// Ready pin synchroniser: a change counts once stages two and three agree
	always @(posedge clock) begin
		if (!rst_n) begin
			// Start as ready so an idle pin cannot stretch the first access
			ready_sync_reg <= `WSG_READY_SYNC_RST;
			ready_ok_reg   <= `WSG_READY_OK_RST;
		end else begin
			ready_sync_reg <= {ready_sync_reg[1:0], ready_pin};
			if (ready_sync_reg[2] == ready_sync_reg[1])
				ready_ok_reg <= ready_sync_reg[1];
		end
	end

	// ==========================================================
	// Access sequencer: software waits first, then ready stretch
	always @(posedge clock) begin
		if (!rst_n) begin
			state_reg <= ST_IDLE;
			count_reg <= CNT_ZERO;
			acc_wait  <= 1'b0;
			acc_done  <= 1'b0;
			clk_gated <= 1'b0;
		end else begin
			acc_done  <= 1'b0;
			clk_gated <= all_zero;
			case (state_reg)
				ST_IDLE: begin
					if (acc_start) begin
						if (total_sel != CNT_ZERO && count_en) begin
							count_reg <= total_sel;
							acc_wait  <= 1'b1;
							state_reg <= ST_COUNT;
						end else begin
							// Nothing to count: go straight to the ready check
							acc_wait  <= 1'b1;
							state_reg <= ST_READY;
						end
					end
				end
				ST_COUNT: begin
					if (count_en)
						count_reg <= count_reg - CNT_ONE;
					// Clearing every field mid-access must not strand the counter
					if (count_reg == CNT_ONE || !count_en)
						state_reg <= ST_READY;
				end
				ST_READY: begin
					// Ready low keeps stretching past the programmed count
					if (ready_ok_reg) begin
						acc_wait  <= 1'b0;
						acc_done  <= 1'b1;
						state_reg <= ST_IDLE;
					end
				end
				default: begin
					state_reg <= ST_IDLE;
					acc_wait  <= 1'b0;
				end
			endcase
		end
	end

endmodule // wsg_wait_state_gen
`default_nettype wire

// ---- wsg_bus_partner.sv ----
// Far-side memory model that holds the ready pin low for a chosen stall
`timescale 1ns/10ps
`default_nettype none
module wsg_bus_partner (
	input  wire logic       clock,
	input  wire logic       rst_n,
	input  wire logic       acc_wait,
	input  wire logic [7:0] stall,
	output var  logic       ready_pin
);
	logic [7:0] cnt_reg;
	logic       w_reg;
	// Slow device: ready drops as the access begins, for stall cycles
	always @(posedge clock) begin
		w_reg <= acc_wait;
		if (!rst_n)
			cnt_reg <= 8'h00;
		else if (acc_wait && !w_reg)
			cnt_reg <= stall;
		else if (cnt_reg != 8'h00)
			cnt_reg <= cnt_reg - 8'h01;
	end
	assign ready_pin = (cnt_reg == 8'h00);
endmodule // wsg_bus_partner
`default_nettype wire

// ---- wsg_checker.sv ----
// Port-level assertions for the wait-state generator
`timescale 1ns/10ps
`default_nettype none
module wsg_checker (
	input wire logic        clock, rst_n, mmr_wr, mmr_rd, acc_start,
	input wire logic        acc_wait, acc_done, ready_pin, clk_gated,
	input wire logic [15:0] mmr_addr, mmr_wdata, mmr_rdata
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	sequence s_take; acc_start && !acc_wait && !acc_done; endsequence
	sequence s_zero_wr; mmr_wr && mmr_addr == 16'h0028 && mmr_wdata[14:0] == 15'h0000; endsequence
	AST_CTRL_RSVD: assert property (mmr_rd && mmr_addr == 16'h002B |=> mmr_rdata[15:1] == 15'h0000)
		else $error("reserved control bits not zero");
	AST_RD_IDLE: assert property (!mmr_rd |=> mmr_rdata == 16'h0000) else $error("read data not idle");
	AST_DONE_PULSE: assert property (acc_done |=> !acc_done) else $error("done longer than a cycle");
	AST_WAIT_RISE: assert property (s_take |=> acc_wait) else $error("wait did not rise");
	AST_DONE_END: assert property (acc_done |-> !acc_wait) else $error("wait high with done");
	// Ready held high bounds the stretch to fourteen waits plus sequencing
	AST_MAX_STRETCH: assert property ($rose(acc_wait) |-> (##[1:17] acc_done) or (##[0:17] !ready_pin))
		else $error("stretch too long");
	AST_READY_HOLD: assert property (!ready_pin [*6] |-> !acc_done) else $error("done while not ready");
	AST_GATE_ON: assert property (s_zero_wr |-> ##[1:3] clk_gated) else $error("gating missing");
	AST_GATE_OFF: assert property (mmr_wr && mmr_addr == 16'h0028 && mmr_wdata[14:0] != 15'h0000
		|-> ##[1:3] !clk_gated) else $error("gating stuck");
endmodule // wsg_checker
bind wsg_wait_state_gen wsg_checker u_chk (.clock(clock), .rst_n(rst_n), .mmr_wr(mmr_wr),
	.mmr_rd(mmr_rd), .acc_start(acc_start), .acc_wait(acc_wait), .acc_done(acc_done),
	.ready_pin(ready_pin), .clk_gated(clk_gated), .mmr_addr(mmr_addr),
	.mmr_wdata(mmr_wdata), .mmr_rdata(mmr_rdata));
`default_nettype wire

// ---- test_external_bus_wait_state_generator.sv ----
// Self-checking bench for the wait-state generator
`timescale 1ns/10ps
`default_nettype none
module test_external_bus_wait_state_generator;
	logic clock = 0, rst_n = 0, mmr_wr = 0, mmr_rd = 0, acc_start = 0, acc_wait, acc_done, rdy, gated;
	logic [15:0] mmr_addr = 16'h0000, mmr_wdata = 16'h0000, rdata;
	logic [1:0] space = 2'h0;
	logic [19:0] addr = 20'h00000;
	logic [7:0] stall = 8'h00;
	int n_errors = 0, samples_checked = 0;
	always #10 clock = ~clock;
	wsg_wait_state_gen DUT (.clock(clock), .rst_n(rst_n), .mmr_addr(mmr_addr), .mmr_wr(mmr_wr),
		.mmr_rd(mmr_rd), .mmr_wdata(mmr_wdata), .mmr_rdata(rdata), .acc_start(acc_start),
		.acc_space(space), .acc_addr(addr), .acc_wait(acc_wait), .acc_done(acc_done),
		.ready_pin(rdy), .clk_gated(gated));
	wsg_bus_partner u_mem (.clock(clock), .rst_n(rst_n), .acc_wait(acc_wait), .stall(stall),
		.ready_pin(rdy));
	task end_sim;
		$display("errors %0d checks %0d", n_errors, samples_checked);
		if (n_errors == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task chk_word(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %0t word %h expected %h", $time, got, exp);
		end
	endtask
	task chk_cyc(input int got, input int lo, input int hi);
		samples_checked++;
		if (got < lo || got > hi) begin
			n_errors++;
			$display("[ERR] %0t cycles %0d expected %0d..%0d", $time, got, lo, hi);
		end
	endtask
	task wr(input logic [15:0] a, input logic [15:0] d);
		mmr_addr = a; mmr_wdata = d; mmr_wr = 1;
		@(posedge clock); #1 mmr_wr = 0;
		@(posedge clock); #1;
	endtask
	task rd(input logic [15:0] a, input logic [15:0] exp);
		mmr_addr = a; mmr_rd = 1;
		@(posedge clock); #1 mmr_rd = 0;
		chk_word(rdata, exp);
		@(posedge clock); #1;
	endtask
	// Counts edges from the taking edge to the done pulse
	task acc(input logic [1:0] s, input logic [19:0] a, input int lo, input int hi);
		int n;
		space = s; addr = a; acc_start = 1;
		@(posedge clock); #1 acc_start = 0;
		chk_word({15'h0000, acc_wait}, 16'h0001);
		for (n = 1; n < 100; n++) begin
			@(posedge clock); #1;
			if (acc_done === 1'b1) break;
		end
		if (n == 100) begin n_errors++; end_sim(); end
		chk_cyc(n, lo, hi);
		chk_word({15'h0000, acc_wait}, 16'h0000);
	endtask
	task s_reset;
		rd(16'h0028, 16'h7FFF);
		rd(16'h002B, 16'h0000);
		acc(2'h1, 20'h08000, 8, 8);
	endtask
	task s_regs;
		wr(16'h002B, 16'hFFFF);
		rd(16'h002B, 16'h0001);
		rd(16'h0030, 16'h0000);
		acc(2'h2, 20'h0FFFF, 15, 15);
	endtask
	task s_fields;
		wr(16'h0028, 16'h14E5);
		acc(2'h2, 20'h00000, 3, 3);
		acc(2'h1, 20'h0C000, 5, 5);
		acc(2'h1, 20'h01000, 7, 7);
		acc(2'h0, 20'h38000, 9, 9);
		acc(2'h0, 20'h57FFF, 11, 11);
		wr(16'h002B, 16'h0000);
		wr(16'h0028, 16'h94E5);
		acc(2'h0, 20'hF8000, 6, 6);
	endtask
	task s_ready_gate;
		stall = 8'd20;
		acc(2'h0, 20'h0C000, 21, 27);
		stall = 8'd0;
		wr(16'h0028, 16'h8000);
		acc(2'h1, 20'h00000, 1, 1);
		chk_word({15'h0000, gated}, 16'h0001);
		// Mid-run reset brings back seven waits everywhere and ungates
		rst_n = 0;
		@(posedge clock); #1 rst_n = 1;
		rd(16'h0028, 16'h7FFF);
		chk_word({15'h0000, gated}, 16'h0000);
	endtask
	initial begin
		repeat (4) @(posedge clock);
		#1 rst_n = 1;
		s_reset();
		s_regs();
		s_fields();
		s_ready_gate();
		end_sim();
	end
endmodule // test_external_bus_wait_state_generator
`default_nettype wire
